// ==== core/io_addr_decode.sv ====
// io address decoder: one destination per address
`timescale 1ns/10ps
module io_addr_decode (
  // address in
  input wire logic [15:0] ioAddr,
  // one-hot destination
  output logic hitOnboard,
  output logic hitExtBus,
  output logic hitNone
);
  logic [1:0] dest;
  logic found;
  always_comb begin
    dest = irq_route_pkg::DEST_EXTBUS;
    found = 1'b0;
    for (int i = 0; i < irq_route_pkg::NUM_RANGES; i++) begin
      if (!found
          && ioAddr >= irq_route_pkg::RANGE_TAB[(irq_route_pkg::NUM_RANGES-1-i)*34+18 +: 16]
          && ioAddr <= irq_route_pkg::RANGE_TAB[(irq_route_pkg::NUM_RANGES-1-i)*34+2 +: 16]) begin
        dest = irq_route_pkg::RANGE_TAB[(irq_route_pkg::NUM_RANGES-1-i)*34 +: 2];
        found = 1'b1;
      end
    end
    hitOnboard = (dest == irq_route_pkg::DEST_ONBOARD);
    hitExtBus = (dest == irq_route_pkg::DEST_EXTBUS);
    hitNone = (dest == irq_route_pkg::DEST_NONE);
  end
endmodule

// ==== core/irq_router.sv ====
// interrupt, dma request routing and io decode glue
`timescale 1ns/10ps
// Contract
// - system event is OR of three sources
// - power-fail flag feeds system event
// - system event routed to NMI, IRQ7 or IRQ15
// - USB on IRQ6, IRQ5 if LPT off
// - IRQ12 alternatives only without PS/2 mouse
// - ISA channel check may drive NMI
// - RTC alone on IRQ8
// - IDE on IRQ14, ISA alternative
// - DRQ1 LPT or ISA, others ISA, DRQ0 and DRQ4 unused
// - unclaimed gap ranges forwarded to ISA
// - reserved ranges neither answered nor forwarded
module irq_router (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // event sources from pins
  input wire logic powerFailIn,
  input wire logic extWdogIn,
  input wire logic optoIn,
  input wire logic intWdogIn,
  input wire logic chanCheckIn,
  // onboard interrupt sources
  input wire logic [15:0] boardIrqIn,
  input wire logic usbIrqIn,
  // external isa lines
  input wire logic [15:0] isaIrqIn,
  input wire logic [7:0] isaDrqIn,
  input wire logic lptDrqIn,
  // configuration
  input wire logic [1:0] evtRouteSel,
  input wire logic [1:0] nmiSrcSel,
  input wire logic lptEnable,
  input wire logic mouseEnable,
  input wire logic [15:0] altSelect,
  // io address in
  input wire logic [15:0] ioAddr,
  // outputs to host
  output logic nmiOut,
  output logic [15:0] irqOut,
  output logic [7:0] drqOut,
  output logic sysEventOut,
  output logic ioOnboard,
  output logic ioExtBus,
  output logic ioNone
);
  // pin synchronisers
  logic [5:0] pinMeta_q, pinSync_q;
  logic [15:0] isaIrqMeta_q, isaIrqSync_q;
  logic [7:0] isaDrqMeta_q, isaDrqSync_q;
  logic pinPfail, pinExtWd, pinOpto, pinIntWd, pinChk, pinLptDrq;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_q <= 6'h00;
      pinSync_q <= 6'h00;
      isaIrqMeta_q <= 16'h0000;
      isaIrqSync_q <= 16'h0000;
      isaDrqMeta_q <= 8'h00;
      isaDrqSync_q <= 8'h00;
    end else begin
      pinMeta_q <= {lptDrqIn, chanCheckIn, intWdogIn, optoIn, extWdogIn, powerFailIn};
      pinSync_q <= pinMeta_q;
      isaIrqMeta_q <= isaIrqIn;
      isaIrqSync_q <= isaIrqMeta_q;
      isaDrqMeta_q <= isaDrqIn;
      isaDrqSync_q <= isaDrqMeta_q;
    end
  end
  assign {pinLptDrq, pinChk, pinIntWd, pinOpto, pinExtWd, pinPfail} = pinSync_q;

  // routing
  logic sysEvent;
  logic nmi_d, nmi_q;
  logic [15:0] irq_d, irq_q;
  logic [7:0] drq_d, drq_q;
  logic sevt_q;
  logic usbLine;
  always_comb begin
    sysEvent = pinPfail | pinExtWd | pinOpto;
    irq_d = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      irq_d[i] = altSelect[i] ? isaIrqSync_q[i] : boardIrqIn[i];
    end
    usbLine = 1'b0;
    // usb lands on 6, or on 5 when the parallel port is off
    if (lptEnable) begin
      irq_d[irq_route_pkg::IRQ_USB_DEF] = usbIrqIn
        | (altSelect[irq_route_pkg::IRQ_USB_DEF] & isaIrqSync_q[irq_route_pkg::IRQ_USB_DEF]);
    end else begin
      irq_d[irq_route_pkg::IRQ_LPT] = usbIrqIn
        | (altSelect[irq_route_pkg::IRQ_LPT] & isaIrqSync_q[irq_route_pkg::IRQ_LPT]);
      usbLine = 1'b1;
    end
    // mouse line opens to alternatives only with mouse support off
    if (mouseEnable) begin
      irq_d[irq_route_pkg::IRQ_MOUSE] = boardIrqIn[irq_route_pkg::IRQ_MOUSE];
    end else begin
      irq_d[irq_route_pkg::IRQ_MOUSE] = altSelect[irq_route_pkg::IRQ_MOUSE]
        ? isaIrqSync_q[irq_route_pkg::IRQ_MOUSE] : usbIrqIn & ~usbLine;
    end
    irq_d[irq_route_pkg::IRQ_RTC] = boardIrqIn[irq_route_pkg::IRQ_RTC];
    irq_d[irq_route_pkg::IRQ_IDE] = altSelect[irq_route_pkg::IRQ_IDE]
      ? isaIrqSync_q[irq_route_pkg::IRQ_IDE] : boardIrqIn[irq_route_pkg::IRQ_IDE];
    nmi_d = 1'b0;
    case (evtRouteSel)
      irq_route_pkg::EVT_TO_NMI: nmi_d = sysEvent;
      irq_route_pkg::EVT_TO_IRQ7: irq_d[irq_route_pkg::IRQ_SEVT_A] = sysEvent;
      irq_route_pkg::EVT_TO_IRQ15: irq_d[irq_route_pkg::IRQ_SEVT_B] = sysEvent;
      default: ;
    endcase
    case (nmiSrcSel)
      irq_route_pkg::NMI_FROM_WDOG: nmi_d = nmi_d | pinIntWd;
      irq_route_pkg::NMI_FROM_CHK: nmi_d = nmi_d | pinChk;
      default: ;
    endcase
    drq_d = isaDrqSync_q;
    drq_d[irq_route_pkg::DRQ_UNUSED] = 1'b0;
    drq_d[4] = 1'b0;
    drq_d[irq_route_pkg::DRQ_LPT] = lptEnable ? pinLptDrq
      : isaDrqSync_q[irq_route_pkg::DRQ_LPT];
  end

  // io decode
  logic decOn, decExt, decNone;
  logic ioOn_q, ioExt_q, ioNone_q;
  io_addr_decode uDecode (
    .ioAddr(ioAddr),
    .hitOnboard(decOn),
    .hitExtBus(decExt),
    .hitNone(decNone)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_q <= 1'b0;
      irq_q <= 16'h0000;
      drq_q <= 8'h00;
      sevt_q <= 1'b0;
      ioOn_q <= 1'b0;
      ioExt_q <= 1'b0;
      ioNone_q <= 1'b1;
    end else begin
      nmi_q <= nmi_d;
      irq_q <= irq_d;
      drq_q <= drq_d;
      sevt_q <= sysEvent;
      ioOn_q <= decOn;
      ioExt_q <= decExt;
      ioNone_q <= decNone;
    end
  end
  assign nmiOut = nmi_q;
  assign irqOut = irq_q;
  assign drqOut = drq_q;
  assign sysEventOut = sevt_q;
  assign ioOnboard = ioOn_q;
  assign ioExtBus = ioExt_q;
  assign ioNone = ioNone_q;

  // checks
  a_decode_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot({ioOnboard, ioExtBus, ioNone})) else $error("io decode not one-hot");
  a_gap_forward: assert property (@(posedge clk) disable iff (rst)
    (ioAddr >= 16'h0024 && ioAddr <= 16'h002D) |=> ioExtBus)
    else $error("gap not forwarded");
  a_reserved_silent: assert property (@(posedge clk) disable iff (rst)
    (ioAddr >= 16'h002E && ioAddr <= 16'h002F) |=> ioNone && !ioExtBus)
    else $error("reserved range answered");
  a_event_or: assert property (@(posedge clk) disable iff (rst)
    (pinPfail || pinExtWd || pinOpto) |=> sysEventOut)
    else $error("system event missing");
  a_pfail_event: assert property (@(posedge clk) disable iff (rst)
    pinPfail |=> sysEventOut) else $error("power fail lost");
  a_event_irq15: assert property (@(posedge clk) disable iff (rst)
    (evtRouteSel == irq_route_pkg::EVT_TO_IRQ15) |=> irqOut[15] == $past(sysEvent))
    else $error("event not on irq15");
  a_usb_irq5: assert property (@(posedge clk) disable iff (rst)
    (!lptEnable && usbIrqIn) |=> irqOut[5]) else $error("usb not on irq5");
  a_mouse_only: assert property (@(posedge clk) disable iff (rst)
    mouseEnable |=> irqOut[12] == $past(boardIrqIn[12]))
    else $error("irq12 alternative with mouse on");
  a_chk_nmi: assert property (@(posedge clk) disable iff (rst)
    (nmiSrcSel == irq_route_pkg::NMI_FROM_CHK && pinChk) |=> nmiOut)
    else $error("channel check not on nmi");
  a_rtc_only: assert property (@(posedge clk) disable iff (rst)
    ##1 irqOut[8] == $past(boardIrqIn[8])) else $error("irq8 not rtc");
  a_ide_default: assert property (@(posedge clk) disable iff (rst)
    !altSelect[14] |=> irqOut[14] == $past(boardIrqIn[14]))
    else $error("irq14 not ide");
  a_drq0_idle: assert property (@(posedge clk) disable iff (rst)
    !drqOut[0]) else $error("drq0 driven");
  a_drq4_idle: assert property (@(posedge clk) disable iff (rst)
    !drqOut[4]) else $error("drq4 driven");
  a_wdog_nmi: assert property (@(posedge clk) disable iff (rst)
    (nmiSrcSel == irq_route_pkg::NMI_FROM_WDOG && pinIntWd) |=> nmiOut)
    else $error("watchdog not on nmi");
  a_usb_irq6: assert property (@(posedge clk) disable iff (rst)
    (lptEnable && usbIrqIn) |=> irqOut[6]) else $error("usb not on irq6");
endmodule

// ==== inc/irq_route_pkg.sv ====
// constants for interrupt routing and io address decode
package irq_route_pkg;
  // system-event routing select
  localparam logic [1:0] EVT_TO_NMI = 2'h0;
  localparam logic [1:0] EVT_TO_IRQ7 = 2'h1;
  localparam logic [1:0] EVT_TO_IRQ15 = 2'h2;
  localparam logic [1:0] EVT_TO_NONE = 2'h3;
  // nmi source select
  localparam logic [1:0] NMI_FROM_WDOG = 2'h0;
  localparam logic [1:0] NMI_FROM_EVT = 2'h1;
  localparam logic [1:0] NMI_FROM_CHK = 2'h2;
  // io decode destinations
  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_ONBOARD = 2'h1;
  localparam logic [1:0] DEST_EXTBUS = 2'h2;
  // irq and drq line positions, decode sizes
  localparam int IRQ_LPT = 5;
  localparam int IRQ_USB_DEF = 6;
  localparam int IRQ_SEVT_A = 7;
  localparam int IRQ_RTC = 8;
  localparam int IRQ_MOUSE = 12;
  localparam int IRQ_IDE = 14;
  localparam int IRQ_SEVT_B = 15;
  localparam int DRQ_LPT = 1;
  localparam int DRQ_UNUSED = 0;
  localparam int ADDR_W = 16;
  localparam int NUM_RANGES = 28;
  // decode table: lo, hi, destination
  localparam logic [NUM_RANGES*34-1:0] RANGE_TAB = {
    16'h0000, 16'h001F, DEST_ONBOARD,
    16'h0020, 16'h0021, DEST_ONBOARD,
    16'h0022, 16'h0023, DEST_ONBOARD,
    16'h0024, 16'h002D, DEST_EXTBUS,
    16'h002E, 16'h002F, DEST_NONE,
    16'h0030, 16'h003F, DEST_EXTBUS,
    16'h0040, 16'h0043, DEST_ONBOARD,
    16'h0044, 16'h0047, DEST_EXTBUS,
    16'h0048, 16'h004B, DEST_NONE,
    16'h004E, 16'h005F, DEST_EXTBUS,
    16'h0060, 16'h0064, DEST_ONBOARD,
    16'h0065, 16'h0065, DEST_ONBOARD,
    16'h0066, 16'h0066, DEST_EXTBUS,
    16'h0067, 16'h006D, DEST_ONBOARD,
    16'h006E, 16'h006F, DEST_EXTBUS,
    16'h0070, 16'h007F, DEST_ONBOARD,
    16'h0080, 16'h009F, DEST_ONBOARD,
    16'h00A0, 16'h00B1, DEST_ONBOARD,
    16'h00B2, 16'h00BF, DEST_EXTBUS,
    16'h00C0, 16'h00DF, DEST_ONBOARD,
    16'h00E0, 16'h01EF, DEST_EXTBUS,
    16'h01F0, 16'h01F8, DEST_ONBOARD,
    16'h01F9, 16'h0277, DEST_EXTBUS,
    16'h04D0, 16'h04D1, DEST_NONE,
    16'h0778, 16'h077F, DEST_NONE,
    16'hEE00, 16'hEF3F, DEST_NONE,
    16'hFC00, 16'hFC0D, DEST_NONE,
    16'hFFF0, 16'hFFFF, DEST_NONE
  };
endpackage

// ==== sim/isa_dev_model.sv ====
// behavioural isa add-in cards raising irq and dma requests
`timescale 1ns/10ps
module isa_dev_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests the cards should raise
  input wire logic [15:0] irqReq,
  input wire logic [7:0] drqReq,
  // isa request lines
  output logic [15:0] isaIrq,
  output logic [7:0] isaDrq
);
  always_ff @(posedge clk) begin
    if (rst) begin
      isaIrq <= 16'h0000;
      isaDrq <= 8'h00;
    end else begin
      isaIrq <= irqReq;
      isaDrq <= drqReq;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// testbench for interrupt routing and io decode glue
`timescale 1ns/10ps
module testbench;
  logic clk, rst, powerFailIn, extWdogIn, optoIn, intWdogIn, chanCheckIn;
  logic usbIrqIn, lptDrqIn, lptEnable, mouseEnable;
  logic [15:0] boardIrqIn, altSelect, ioAddr, irqReq, isaIrqIn, irqOut;
  logic [7:0] drqReq, isaDrqIn, drqOut;
  logic [1:0] evtRouteSel, nmiSrcSel;
  logic nmiOut, sysEventOut, ioOnboard, ioExtBus, ioNone;
  int failures, comparisons;
  isa_dev_model isa_u (.clk, .rst, .irqReq, .drqReq, .isaIrq(isaIrqIn), .isaDrq(isaDrqIn));
  irq_router dut_u (.clk, .rst, .powerFailIn, .extWdogIn, .optoIn, .intWdogIn,
    .chanCheckIn, .boardIrqIn, .usbIrqIn, .isaIrqIn, .isaDrqIn, .lptDrqIn,
    .evtRouteSel, .nmiSrcSel, .lptEnable, .mouseEnable, .altSelect, .ioAddr,
    .nmiOut, .irqOut, .drqOut, .sysEventOut, .ioOnboard, .ioExtBus, .ioNone);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  // quiet inputs, called at time zero and right after a rising edge
  task automatic idle();
    {powerFailIn, extWdogIn, optoIn, intWdogIn, chanCheckIn} <= 5'h00;
    {usbIrqIn, lptDrqIn} <= 2'h0;
    {boardIrqIn, altSelect, irqReq, ioAddr} <= 64'h0000_0000_0000_0000;
    drqReq <= 8'h00;
    evtRouteSel <= irq_route_pkg::EVT_TO_NONE;
    nmiSrcSel <= irq_route_pkg::NMI_FROM_EVT;
    {lptEnable, mouseEnable} <= 2'h3;
  endtask
  task automatic fresh();
    @(posedge clk);
    idle();
    settle();
    @(posedge clk);
  endtask
  task automatic t_event();
    for (int i = 0; i < 3; i++) begin
      fresh();
      {powerFailIn, extWdogIn, optoIn} <= 3'h1 << i;
      evtRouteSel <= irq_route_pkg::EVT_TO_IRQ7;
      settle();
      chk({sysEventOut, irqOut[7]}, 2'h3);
      @(posedge clk);
      evtRouteSel <= irq_route_pkg::EVT_TO_IRQ15;
      settle();
      chk({irqOut[15], irqOut[7]}, 2'h2);
      @(posedge clk);
      evtRouteSel <= irq_route_pkg::EVT_TO_NMI;
      settle();
      chk({nmiOut, irqOut[15]}, 2'h2);
      @(posedge clk);
      {powerFailIn, extWdogIn, optoIn} <= 3'h0;
      settle();
      chk({sysEventOut, nmiOut}, 2'h0);
    end
  endtask
  task automatic t_nmi();
    fresh();
    chanCheckIn <= 1'h1;
    nmiSrcSel <= irq_route_pkg::NMI_FROM_CHK;
    settle();
    chk(nmiOut, 1'h1);
    @(posedge clk);
    nmiSrcSel <= irq_route_pkg::NMI_FROM_WDOG;
    settle();
    chk(nmiOut, 1'h0);
    @(posedge clk);
    intWdogIn <= 1'h1;
    settle();
    chk(nmiOut, 1'h1);
  endtask
  task automatic t_usb();
    fresh();
    usbIrqIn <= 1'h1;
    settle();
    chk({irqOut[6], irqOut[5]}, 2'h2);
    @(posedge clk);
    lptEnable <= 1'h0;
    settle();
    chk({irqOut[6], irqOut[5]}, 2'h1);
    fresh();
    irqReq <= 16'h1000;
    altSelect <= 16'h1000;
    settle();
    chk(irqOut[12], 1'h0);
    @(posedge clk);
    mouseEnable <= 1'h0;
    settle();
    chk(irqOut[12], 1'h1);
  endtask
  task automatic t_fixed();
    fresh();
    altSelect <= 16'hFFFF;
    irqReq <= 16'h4100;
    drqReq <= 8'hFF;
    lptEnable <= 1'h0;
    settle();
    chk({irqOut[14], irqOut[8]}, 2'h2);
    chk(drqOut, 8'hEE);
    @(posedge clk);
    altSelect <= 16'h0000;
    boardIrqIn <= 16'h0100;
    lptEnable <= 1'h1;
    settle();
    chk({irqOut[14], irqOut[8]}, 2'h1);
    chk(drqOut, 8'hEC);
  endtask
  task automatic t_decode();
    logic [18:0] tab [8];
    tab = '{{16'h0022, 3'h4}, {16'h0023, 3'h4}, {16'h0024, 3'h2}, {16'h002D, 3'h2},
      {16'h002E, 3'h1}, {16'h002F, 3'h1}, {16'h0030, 3'h2}, {16'h0065, 3'h4}};
    fresh();
    foreach (tab[i]) begin
      ioAddr <= tab[i][18:3];
      settle();
      chk({ioOnboard, ioExtBus, ioNone}, tab[i][2:0]);
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 3000);
    failures++;
    print_verdict();
  end
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'h1;
    idle();
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_event();
    t_nmi();
    t_usb();
    t_fixed();
    t_decode();
    print_verdict();
  end
endmodule
